// file: rtl/icc_consts.svh
// Purpose: Constants for the core interrupt control CSR block.
// Assumes: CSR addresses are 12 bits, data is 32 bits.
// Notes: Offsets, field positions and reset values live here; bits 1:0 and one-bit resets are written in place.
`ifndef ICC_CONSTS_SVH
`define ICC_CONSTS_SVH
// ==========================================================
// CSR addresses
`define ICC_A_MSTAT 12'h300
`define ICC_A_TVEC 12'h305
`define ICC_A_UVIEW 12'h800
`define ICC_A_ISC 12'h804
`define ICC_A_FCFG 12'hbc0
`define ICC_A_NEST 12'hbc1
// ==========================================================
// Field positions
`define ICC_B_GIE 3
`define ICC_B_PGIE 7
`define ICC_B_PPL 11
`define ICC_B_PPH 12
`define ICC_B_SKIP 5
`define ICC_B_NEST_OK 1
`define ICC_B_ACS 0
`define ICC_B_FNMI 7
`define ICC_B_UVIEW 5
`define ICC_B_LOOP 3
`define ICC_B_JUMP 2
`define ICC_B_OVF 30
`define ICC_B_DEPL 8
`define ICC_B_DEPH 11
`define ICC_B_SEV 5
`define ICC_B_SEVP 4
`define ICC_B_W2E 3
`define ICC_B_DEEP 2
`define ICC_B_SOE 1
// ==========================================================
// Fixed and reset values
`define ICC_ISC_FIXED 32'h0000_0002
`define ICC_FETCH_RST 2'h1
`define ICC_FETCH_OFF 2'h0
`define ICC_LIM_ON 2'h1
`define ICC_LIM_OFF 2'h0
`define ICC_PRIV_U 2'h0
`define ICC_PRIV_M 2'h3
`define ICC_DEP0 4'h0
`define ICC_DEP1 4'h1
`define ICC_DEP2 4'h3
`define ICC_DEP3 4'h7
`define ICC_TVEC_ZMASK 32'hffff_fc03
`define ICC_VEC_BASE 32'h0000_0000
`define ICC_LOOP_FULL 9'h080
`define ICC_LOOP_PART 9'h100
`endif

// file: rtl/icc_pkg.sv
// Purpose: Types for the core interrupt control CSR block.
// Assumes: Used with icc_consts.svh.
// Notes: Request and event groups travel as packed structs.
package icc_pkg;
   // CSR request from the pipeline.
   typedef struct packed {
      logic valid;
      logic write;
      logic [11:0] addr;
      logic [31:0] wdata;
      logic machine;
   } icc_csr_req_type;
   // Pipeline trap and wait events.
   typedef struct packed {
      logic irq_entry;
      logic irq_exit;
      logic exc_return;
      logic wait_event;
      logic wait_sleep;
      logic core_fault;
      logic nmi_entry;
   } icc_evt_type;
   // Low-power verdict for the pipeline.
   typedef enum logic [1:0] {icc_run_type_run, icc_run_type_sleep, icc_run_type_deep}
      icc_lp_type;
   typedef enum {icc_awake, icc_waiting} icc_wait_state_type;
endpackage : icc_pkg

// file: rtl/icc_csr_core.sv
// Purpose: Interrupt control, wait and fetch policy CSRs inside the core.
// Assumes: One clock, async active-low reset; requests come from core logic.
// Notes: Answers appear one cycle after a valid request.
//        Policy outputs follow their registers one edge later.
`include "icc_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module icc_csr_core
   import icc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // CSR access
   input wire icc_csr_req_type csr_req,
   output logic csr_ack,
   output logic csr_fault,
   output logic [31:0] csr_rdata,
   // Pipeline events
   input wire icc_evt_type evt,
   input wire logic [31:0] irq_pending,
   input wire logic [31:0] sys_ctrl_wdata,
   input wire logic sys_ctrl_we,
   // Controls to the pipeline
   output logic wake_pulse,
   output logic [1:0] lp_mode,
   output logic resume_main,
   output logic restore_ctx,
   output logic raise_nmi,
   output logic raise_exc,
   output logic [1:0] return_priv,
   output logic vector_mode,
   output logic vector_absolute,
   output logic [31:0] vector_base,
   output logic loop_boost,
   output logic branch_boost,
   output logic [1:0] fetch_policy,
   output logic [3:0] nest_depth
);
   // ==========================================================
   // State
   // Status enables and trap return state.
   logic gie;
   logic pgie;
   logic [1:0] ppriv;

   // Interrupt system control bits.
   logic skip_once;
   logic acs;

   // Fetch configuration bits.
   logic fnmi;
   logic uview;
   logic lboost;
   logic jboost;
   logic [1:0] fpol;

   // Nesting limit and sticky overflow flag.
   logic [1:0] nlim;
   logic ovf;

   // System control bits and the remembered wake event.
   logic sev_pend;
   logic w2e;
   logic deep;
   logic soe;
   logic event_latch;
   icc_wait_state_type wstate;

   // Last cycle's pending lines.
   logic [31:0] pend_q;
   // Trap vector; only the two mode bits are writable.
   logic [31:0] tvec;

   // Decoded request and event terms.
   logic wr;
   logic machine_only;
   logic ok;
   logic new_pend;
   logic sev_now;
   logic ovf_now;

   // A wait instruction; the sleep form is folded in when asked.
   logic do_wait;
   assign do_wait = evt.wait_event | (evt.wait_sleep & w2e);

   // Request decode; only the user view is open below machine mode.
   assign wr = csr_req.valid & csr_req.write;
   assign machine_only = (csr_req.addr != `ICC_A_UVIEW);
   // Machine-only registers refuse any lower-privilege access.
   assign ok = csr_req.machine | ~machine_only;
   // A line counts once, on the first cycle it reads pending.
   assign new_pend = |(irq_pending & ~pend_q);
   assign sev_now = sys_ctrl_we & sys_ctrl_wdata[`ICC_B_SEV];
   // Overflow only when a second-level handler faults or takes an NMI.
   assign ovf_now = (nest_depth == `ICC_DEP2) & (evt.core_fault | evt.nmi_entry);

   // ==========================================================
   // System control bits written over the core's store path.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sev_pend <= 1'b0;
         w2e <= 1'b0;
         deep <= 1'b0;
         soe <= 1'b0;
      end else if (sys_ctrl_we) begin
         // The group is rewritten whole; software keeps bits by read-modify-write.
         sev_pend <= sys_ctrl_wdata[`ICC_B_SEVP];
         w2e <= sys_ctrl_wdata[`ICC_B_W2E];
         deep <= sys_ctrl_wdata[`ICC_B_DEEP];
         soe <= sys_ctrl_wdata[`ICC_B_SOE];
      end
   end

   // Previous pending vector to spot newly pending lines.
   // Reset clears it, so lines pending at release count as new.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pend_q <= 32'h0;
      end else begin
         pend_q <= irq_pending;
      end
   end

   // ==========================================================
   // Event wait: a remembered event lets the next wait finish at once.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wstate <= icc_awake;
         event_latch <= 1'b0;
         wake_pulse <= 1'b0;
      end else begin
         wake_pulse <= 1'b0;
         case (wstate)
            icc_awake: begin
               // A remembered event ends the wait at once and is used up.
               if (do_wait) begin
                  if (event_latch | sev_now | (sev_pend & new_pend)) begin
                     event_latch <= 1'b0;
                     wake_pulse <= 1'b1;
                  end else begin
                     wstate <= icc_waiting;
                  end
               end else if (sev_now | (sev_pend & new_pend)) begin
                  // No wait in progress, so keep it for the next wait.
                  event_latch <= 1'b1;
               end
            end
            icc_waiting: begin
               // Only a fresh event ends a wait already in progress.
               if (sev_now | (sev_pend & new_pend)) begin
                  wstate <= icc_awake;
                  wake_pulse <= 1'b1;
               end
            end
            // An illegal state falls back to awake rather than hang.
            default: wstate <= icc_awake;
         endcase
      end
   end

   // Low-power verdict for waits and handler returns.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         lp_mode <= icc_run_type_run;
         resume_main <= 1'b0;
      end else begin
         // The verdict stands until a wake pulse returns the core to run.
         resume_main <= evt.irq_exit & ~soe;
         if ((do_wait & ~event_latch) | (evt.irq_exit & soe)) begin
            lp_mode <= deep ? icc_run_type_deep : icc_run_type_sleep;
         end else if (wake_pulse) begin
            // A wait that meets a remembered event never leaves run.
            lp_mode <= icc_run_type_run;
         end
      end
   end

   // ==========================================================
   // Status enables and prior privilege.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         gie <= 1'b0;
         pgie <= 1'b0;
         ppriv <= `ICC_PRIV_U;
      end else if (evt.irq_entry) begin
         // Events outrank a same-cycle write to the enables.
         pgie <= gie;
         gie <= 1'b0;
      end else if (evt.irq_exit | evt.exc_return) begin
         gie <= pgie;
      end else if (wr & ok & (csr_req.addr == `ICC_A_MSTAT)) begin
         gie <= csr_req.wdata[`ICC_B_GIE];
         pgie <= csr_req.wdata[`ICC_B_PGIE];
         // Reserved encodings are kept out so return is always defined.
         if ((csr_req.wdata[`ICC_B_PPH:`ICC_B_PPL] == `ICC_PRIV_U) ||
             (csr_req.wdata[`ICC_B_PPH:`ICC_B_PPL] == `ICC_PRIV_M)) begin
            ppriv <= csr_req.wdata[`ICC_B_PPH:`ICC_B_PPL];
         end
      end else if (wr & uview & (csr_req.addr == `ICC_A_UVIEW)) begin
         gie <= csr_req.wdata[`ICC_B_GIE];
         pgie <= csr_req.wdata[`ICC_B_PGIE];
      end
   end

   // Interrupt system control bits.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         skip_once <= 1'b0;
         acs <= 1'b0;
      end else if (evt.irq_exit) begin
         // The exit wins over a skip written in the same cycle.
         skip_once <= 1'b0;
      end else if (wr & ok & (csr_req.addr == `ICC_A_ISC)) begin
         skip_once <= csr_req.wdata[`ICC_B_SKIP];
         acs <= csr_req.wdata[`ICC_B_ACS];
      end
   end

   // Trap vector mode bits; the base field is fixed.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tvec <= `ICC_VEC_BASE;
      end else if (wr & ok & (csr_req.addr == `ICC_A_TVEC)) begin
         // Bits 9:2 stay zero whatever is written.
         tvec <= (`ICC_VEC_BASE | {30'h0, csr_req.wdata[1:0]}) & `ICC_TVEC_ZMASK;
      end
   end

   // Fetch configuration.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fnmi <= 1'b0;
         uview <= 1'b0;
         lboost <= 1'b0;
         jboost <= 1'b0;
         fpol <= `ICC_FETCH_RST;
      end else if (wr & ok & (csr_req.addr == `ICC_A_FCFG)) begin
         // Reserved bits 6 and 4 are not stored.
         fnmi <= csr_req.wdata[`ICC_B_FNMI];
         uview <= csr_req.wdata[`ICC_B_UVIEW];
         lboost <= csr_req.wdata[`ICC_B_LOOP];
         jboost <= csr_req.wdata[`ICC_B_JUMP];
         // Reserved policies are dropped so the pipeline sees a known mode.
         if ((csr_req.wdata[1:0] == `ICC_FETCH_OFF) ||
             (csr_req.wdata[1:0] == `ICC_FETCH_RST)) begin
            fpol <= csr_req.wdata[1:0];
         end
      end
   end

   // ==========================================================
   // Nesting limit, depth and overflow flag.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         nlim <= `ICC_LIM_OFF;
      end else if (wr & ok & (csr_req.addr == `ICC_A_NEST)) begin
         // Values 10 and 11 fold to one level, so readback shows the limit.
         nlim <= (csr_req.wdata[1:0] == `ICC_LIM_OFF) ? `ICC_LIM_OFF : `ICC_LIM_ON;
      end
   end

   // Nesting depth; an exception entry is a level as well.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         nest_depth <= `ICC_DEP0;
      end else if ((evt.irq_entry | evt.nmi_entry | evt.core_fault) & ~evt.irq_exit) begin
         // A fault at depth two reaches 0111, the overflow code.
         // Depth is a thermometer code: shift in a one per level.
         if (nest_depth != `ICC_DEP3) begin
            nest_depth <= {nest_depth[2:0], 1'b1};
         end
      end else if (evt.irq_exit & ~(evt.irq_entry | evt.nmi_entry | evt.core_fault)) begin
         // No way back out once overflowed.
         if (nest_depth != `ICC_DEP3) begin
            nest_depth <= {1'b0, nest_depth[3:1]};
         end
      end
   end

   // Set wins over a write-one clear in the same cycle.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ovf <= 1'b0;
      end else if (ovf_now) begin
         ovf <= 1'b1;
      end else if (wr & ok & (csr_req.addr == `ICC_A_NEST) &
                   csr_req.wdata[`ICC_B_OVF]) begin
         // Writing zero to the flag leaves it as it is.
         ovf <= 1'b0;
      end
   end

   // Hardware error routing.
   // Nesting overflow is the only hardware error this block knows.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         raise_nmi <= 1'b0;
         raise_exc <= 1'b0;
         restore_ctx <= 1'b0;
      end else begin
         raise_nmi <= ovf_now & fnmi;
         raise_exc <= ovf_now & ~fnmi;
         // The restore is held off by skip_once or a cleared enable.
         restore_ctx <= evt.irq_exit & acs & ~skip_once;
      end
   end

   // ==========================================================
   // Read mux; reserved bits read zero, nesting_allowed reads one.
   // A refused or unmapped access reads zero, so nothing leaks.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         csr_ack <= 1'b0;
         csr_fault <= 1'b0;
         csr_rdata <= 32'h0;
      end else begin
         csr_ack <= csr_req.valid & ok;
         csr_fault <= csr_req.valid & ~ok;
         csr_rdata <= 32'h0;
         if (csr_req.valid & ok & ~csr_req.write) begin
            case (csr_req.addr)
               `ICC_A_MSTAT, `ICC_A_UVIEW: begin
                  csr_rdata <= ({30'h0, ppriv} << `ICC_B_PPL) |
                     ({31'h0, pgie} << `ICC_B_PGIE) |
                     ({31'h0, gie} << `ICC_B_GIE);
               end
               `ICC_A_TVEC: csr_rdata <= tvec;
               `ICC_A_ISC: begin
                  csr_rdata <= `ICC_ISC_FIXED | ({31'h0, skip_once} << `ICC_B_SKIP) |
                     ({31'h0, acs} << `ICC_B_ACS);
               end
               `ICC_A_FCFG: begin
                  // Reserved bits 6 and 4 read zero.
                  csr_rdata <= {24'h0, fnmi, 1'b0, uview, 1'b0, lboost, jboost, fpol};
               end
               `ICC_A_NEST: begin
                  csr_rdata <= ({31'h0, ovf} << `ICC_B_OVF) |
                     ({28'h0, nest_depth} << `ICC_B_DEPL) |
                     {30'h0, nlim};
               end
               default: csr_rdata <= 32'h0;
            endcase
         end
      end
   end

   // Policy outputs registered for the fetch and trap logic.
   // Every output comes from a flop, at the cost of one edge of lag.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         return_priv <= `ICC_PRIV_U;
         vector_mode <= 1'b0;
         vector_absolute <= 1'b0;
         vector_base <= `ICC_VEC_BASE;
         loop_boost <= 1'b0;
         branch_boost <= 1'b0;
         fetch_policy <= `ICC_FETCH_RST;
      end else begin
         return_priv <= ppriv;
         vector_mode <= tvec[0];
         vector_absolute <= tvec[1];
         // The mask keeps the mode bits out of the base.
         vector_base <= tvec & ~32'h3;
         loop_boost <= lboost;
         branch_boost <= jboost;
         fetch_policy <= fpol;
      end
   end
endmodule : icc_csr_core
`default_nettype wire

// file: tb/icc_csr_core_monitor.sv
// Purpose: Port checks for the interrupt control CSR block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to every instance of the block.
`include "icc_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module icc_csr_core_monitor
   import icc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Watched ports
   input wire icc_csr_req_type csr_req,
   input wire logic csr_ack,
   input wire logic csr_fault,
   input wire logic [31:0] csr_rdata,
   input wire icc_evt_type evt,
   input wire logic wake_pulse,
   input wire logic [31:0] vector_base,
   input wire logic [1:0] fetch_policy,
   input wire logic [3:0] nest_depth
);
   // ==========================================================
   // Assertions, all in the core clock domain.
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // Decoded request kinds.
   wire logic rd_m = csr_req.valid && csr_req.machine && !csr_req.write;
   wire logic user_bad = csr_req.valid && !csr_req.machine && csr_req.addr != `ICC_A_UVIEW;
   AST_ACK:
   assert property (csr_req.valid && !user_bad |=> csr_ack && !csr_fault)
      else $error("allowed access not acknowledged");
   AST_FAULT:
   assert property (user_bad |=> csr_fault && !csr_ack) else $error("user access not refused");
   AST_NO_SPUR:
   assert property (!csr_req.valid |=> !csr_ack && !csr_fault) else $error("answer without request");
   AST_FAULT_DATA:
   assert property (csr_fault |-> csr_rdata == 32'h0) else $error("refused access returned data");
   AST_ISC_FIXED:
   assert property (rd_m && csr_req.addr == `ICC_A_ISC |=> csr_rdata[4:1] == 4'h1)
      else $error("nesting allowed bit not one");
   AST_TVEC_ZERO:
   assert property (rd_m && csr_req.addr == `ICC_A_TVEC |=> csr_rdata[31:2] == 30'h0)
      else $error("vector base bits not zero");
   AST_BASE:
   assert property (vector_base == `ICC_VEC_BASE) else $error("vector base moved");
   AST_FETCH:
   assert property (fetch_policy == 2'h0 || fetch_policy == 2'h1) else $error("reserved fetch policy");
   AST_DEPTH_CODE:
   assert property (nest_depth inside {4'h0, 4'h1, 4'h3, 4'h7}) else $error("bad depth code");
   AST_DEPTH_UP:
   assert property (evt.irq_entry && !evt.irq_exit && nest_depth == 4'h0 |=> nest_depth == 4'h1)
      else $error("depth not one after entry");
   AST_DEPTH_TOP:
   assert property (nest_depth == 4'h7 |=> nest_depth == 4'h7) else $error("returned from overflow");
   // Main scenarios reached.
   cover property (csr_fault);
   cover property (wake_pulse);
   cover property (nest_depth == 4'h7);
endmodule : icc_csr_core_monitor
bind icc_csr_core icc_csr_core_monitor mon (.core_clk(core_clk), .resetn(resetn),
   .csr_req(csr_req), .csr_ack(csr_ack), .csr_fault(csr_fault), .csr_rdata(csr_rdata),
   .evt(evt), .wake_pulse(wake_pulse), .vector_base(vector_base),
   .fetch_policy(fetch_policy), .nest_depth(nest_depth));
`default_nettype wire

// file: tb/icc_far_model.sv
// Purpose: Pipeline and interrupt controller stand-in.
// Assumes: Commands come from the bench at the rising edge.
// Notes: Control pulses are latched so none is missed.
`timescale 1ns/1ns
`default_nettype none
module icc_far_model
   import icc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Bench commands
   input wire icc_evt_type cmd,
   input wire logic [31:0] pend,
   input wire logic clr,
   // Block side
   output var icc_evt_type evt,
   output logic [31:0] irq_pending,
   input wire logic [4:0] ctl,
   output logic [4:0] seen
);
   // ==========================================================
   // Events last one cycle, since the block acts on every high cycle.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         evt <= '0;
         irq_pending <= '0;
      end else begin
         evt <= cmd;
         irq_pending <= pend;
      end
   end
   // Sticky record of control pulses.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         seen <= '0;
      end else begin
         seen <= clr ? ctl : (seen | ctl);
      end
   end
endmodule : icc_far_model
`default_nettype wire

// file: tb/tb_core_interrupt_control_csrs.sv
// Purpose: Self-checking bench for the interrupt control CSR block.
// Assumes: Inputs change by non-blocking drive at the rising edge.
// Notes: Table rows cover plain accesses; hand tests follow.
`include "icc_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_core_interrupt_control_csrs
   import icc_pkg::*;
   ;
   // ==========================================================
   // Signals
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] x;
   } icc_row_type;
   localparam logic [6:0] ev_in = 7'h40, ev_out = 7'h20, ev_ret = 7'h10;
   localparam logic [6:0] ev_wfe = 7'h08, ev_wfi = 7'h04, ev_flt = 7'h02, ev_nmi = 7'h01;
   logic core_clk, resetn, clr, sys_ctrl_we, csr_ack, csr_fault, wake_pulse, fl;
   logic resume_main, restore_ctx, raise_nmi, raise_exc;
   logic vector_mode, vector_absolute, loop_boost, branch_boost;
   logic [31:0] pend, sys_ctrl_wdata, csr_rdata, vector_base, irq_pending, rd;
   logic [1:0] lp_mode, return_priv, fetch_policy;
   logic [3:0] nest_depth;
   logic [4:0] seen;
   icc_csr_req_type csr_req;
   icc_evt_type cmd, evt;
   int fail_count, num_checks, i;
   icc_row_type rows [14] = '{'{12'h300, 32'hffff_ffff, 32'h1888},
      '{12'h300, 32'h1088, 32'h1888}, '{12'h300, 32'h0, 32'h0},
      '{12'h305, 32'hffff_ffff, 32'h3}, '{12'h305, 32'h0, 32'h0},
      '{12'h804, 32'hffff_ffff, 32'h23}, '{12'h804, 32'h0, 32'h2},
      '{12'hbc0, 32'hffff_ffff, 32'had}, '{12'hbc0, 32'h2, 32'h1}, '{12'hbc0, 32'h0, 32'h0},
      '{12'hbc1, 32'hffff_ffff, 32'h1}, '{12'hbc1, 32'h0, 32'h0},
      '{12'hbc1, 32'h2, 32'h1}, '{12'h123, 32'hffff_ffff, 32'h0}};
   // Block and far side.
   icc_csr_core uut (.core_clk, .resetn, .csr_req, .csr_ack, .csr_fault, .csr_rdata, .evt,
      .irq_pending, .sys_ctrl_wdata, .sys_ctrl_we, .wake_pulse, .lp_mode, .resume_main,
      .restore_ctx, .raise_nmi, .raise_exc, .return_priv, .vector_mode, .vector_absolute,
      .vector_base, .loop_boost, .branch_boost, .fetch_policy, .nest_depth);
   icc_far_model model (.core_clk, .resetn, .cmd, .pend, .clr, .evt, .irq_pending,
      .ctl({wake_pulse, resume_main, restore_ctx, raise_nmi, raise_exc}), .seen);
   // Clock at 50 MHz.
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // ==========================================================
   // Tasks
   task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   // One request; the answer stands just after the edge that takes it.
   task automatic csr(input logic m, input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      csr_req <= '{valid: 1'b1, write: w, addr: a, wdata: d, machine: m};
      @(posedge core_clk);
      csr_req.valid <= 1'b0;
      #1;
      for (n = 0; n < 4 && csr_ack !== 1'b1 && csr_fault !== 1'b1; n++) begin
         @(posedge core_clk);
         #1;
      end
      if (n == 4) begin
         fail_count++;
         $display("unexpected csr answer expected 1 seen 0");
         test_done;
      end
      rd = csr_rdata;
      fl = csr_fault;
      // Policy outputs follow the registers one edge later.
      @(posedge core_clk);
      #1;
   endtask : csr
   task automatic mw(input logic [11:0] a, input logic [31:0] d);
      csr(1'b1, 1'b1, a, d);
   endtask : mw
   task automatic mr(input logic [11:0] a);
      csr(1'b1, 1'b0, a, 32'h0);
   endtask : mr
   // System writes settle two edges after the block takes them, events one edge after.
   task automatic pulse(input logic [6:0] e);
      @(posedge core_clk);
      cmd <= e;
      @(posedge core_clk);
      cmd <= '0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : pulse
   task automatic sysw(input logic [31:0] d);
      @(posedge core_clk);
      sys_ctrl_wdata <= d;
      sys_ctrl_we <= 1'b1;
      @(posedge core_clk);
      sys_ctrl_we <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : sysw
   task automatic clr_seen;
      @(posedge core_clk);
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
   endtask : clr_seen
   task automatic do_reset;
      @(posedge core_clk);
      resetn <= 1'b0;
      pend <= '0;
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
   endtask : do_reset
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   // ==========================================================
   // Main sequence
   initial begin
      resetn = 1'b0;
      clr = 1'b0;
      sys_ctrl_we = 1'b0;
      sys_ctrl_wdata = '0;
      pend = '0;
      cmd = '0;
      csr_req = '0;
      fail_count = 0;
      num_checks = 0;
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      check("fetch_policy", 32'(fetch_policy), `ICC_FETCH_RST);
      mr(`ICC_A_ISC);
      check("isc reset", rd, `ICC_ISC_FIXED);
      $display("test reset done");
      foreach (rows[k]) begin
         mw(rows[k].a, rows[k].d);
         mr(rows[k].a);
         check("row read", rd, rows[k].x);
      end
      $display("test table done");
      // Machine-only places refuse user access; the user view obeys its enable.
      csr(1'b0, 1'b1, `ICC_A_NEST, 32'h0);
      check("user write fault", 32'(fl), 32'h1);
      mr(`ICC_A_NEST);
      check("nest kept", rd, 32'h1);
      csr(1'b0, 1'b1, `ICC_A_UVIEW, 32'h88);
      mr(`ICC_A_MSTAT);
      check("view off", rd, 32'h0);
      mw(`ICC_A_FCFG, 32'h20);
      csr(1'b0, 1'b1, `ICC_A_UVIEW, 32'h88);
      csr(1'b0, 1'b0, `ICC_A_UVIEW, 32'h0);
      check("view on", rd, 32'h88);
      for (i = 0; i < 4; i++) begin
         mw(`ICC_A_TVEC, 32'(i));
         check("vector form", 32'({vector_absolute, vector_mode}), 32'(i));
         mw(`ICC_A_FCFG, 32'(i) << 2);
         check("boosts", 32'({loop_boost, branch_boost}), 32'(i));
      end
      check("fetch off", 32'(fetch_policy), `ICC_FETCH_OFF);
      $display("test access done");
      // Enable stacking on entry and exit.
      mw(`ICC_A_MSTAT, 32'h8);
      pulse(ev_in);
      mr(`ICC_A_MSTAT);
      check("prior enable", 32'(rd[7]), 32'h1);
      check("depth one", 32'(nest_depth), 32'h1);
      mw(`ICC_A_MSTAT, 32'h80);
      pulse(ev_out);
      mr(`ICC_A_MSTAT);
      check("enable back", 32'(rd[3]), 32'h1);
      check("depth zero", 32'(nest_depth), 32'h0);
      for (i = 0; i < 3; i++) begin
         mw(`ICC_A_ISC, (i == 0) ? 32'h21 : 32'(i == 1));
         pulse(ev_in);
         clr_seen;
         pulse(ev_out);
         check("restore", 32'(seen[2]), 32'(i == 1));
         mr(`ICC_A_ISC);
         check("skip cleared", rd, (i == 2) ? 32'h2 : 32'h3);
      end
      for (i = 0; i < 2; i++) begin
         mw(`ICC_A_MSTAT, i ? 32'h0 : 32'h1800);
         pulse(ev_ret);
         check("return priv", 32'(return_priv), i ? 32'h0 : 32'h3);
         sysw(32'(i) << 1);
         pulse(ev_in);
         clr_seen;
         pulse(ev_out);
         check("resume main", 32'(seen[3]), 32'(i == 0));
         check("exit power", 32'(lp_mode), 32'(i));
      end
      $display("test trap done");
      // Wait, wake by software event, and wake remembered from new pending lines.
      do_reset;
      for (i = 0; i < 2; i++) begin
         sysw(32'(i) << 2);
         pulse(ev_wfe);
         check("sleep kind", 32'(lp_mode), 32'(i + 1));
         clr_seen;
         sysw(32'h20 | (32'(i) << 2));
         check("event wake", 32'(seen[4]), 32'h1);
         check("awake", 32'(lp_mode), 32'h0);
      end
      for (i = 0; i < 2; i++) begin
         sysw(i ? 32'h18 : 32'h10);
         @(posedge core_clk);
         pend <= pend | (32'h1 << i);
         repeat (3) @(posedge core_clk);
         clr_seen;
         pulse(i ? ev_wfi : ev_wfe);
         check("pending wake", 32'(seen[4]), 32'h1);
      end
      $display("test wake done");
      // Overflow on each fault route, then the write-one clear.
      for (i = 0; i < 2; i++) begin
         do_reset;
         mw(`ICC_A_NEST, 32'h1);
         mw(`ICC_A_FCFG, 32'(i) << 7);
         clr_seen;
         pulse(ev_in);
         pulse(ev_in);
         pulse(i ? ev_nmi : ev_flt);
         check("depth top", 32'(nest_depth), 32'h7);
         check("fault route", 32'(seen[1:0]), i ? 32'h2 : 32'h1);
         mw(`ICC_A_NEST, 32'h1);
         mr(`ICC_A_NEST);
         check("overflow kept", 32'(rd[30]), 32'h1);
         check("depth field", 32'(rd[11:8]), 32'h7);
         mw(`ICC_A_NEST, 32'h4000_0001);
         mr(`ICC_A_NEST);
         check("overflow cleared", 32'(rd[30]), 32'h0);
      end
      $display("test overflow done");
      test_done;
   end
endmodule : tb_core_interrupt_control_csrs
`default_nettype wire
